/* hw/irq2_trigger_unit.sv */
// per-source trigger detection and sticky status for the second interrupt bank
`timescale 1ns/1ps
`default_nettype none

module irq2_trigger_unit #(
  parameter int N = 6
) (
  // clocking
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // configuration
  input  wire logic [N-1:0] mode_high,
  input  wire logic [N-1:0] mode_low,
  input  wire logic [N-1:0] mask,
  // source conditions and read strobe
  input  wire logic [N-1:0] src,
  input  wire logic         rd_clear,
  // results
  output logic      [N-1:0] hit,
  output logic      [N-1:0] keep,
  output logic      [N-1:0] status_q
);

  logic [N-1:0] src_prev_q;

  // previous source level, for edge detection
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      src_prev_q <= '0;
    end else if (ce) begin
      src_prev_q <= src;
    end
  end

  localparam logic [1:0] TRIG_ARRIVE_C = rx_regs_pkg::TRIG_ARRIVE;
  localparam logic [1:0] TRIG_DEPART_C = rx_regs_pkg::TRIG_DEPART;
  localparam logic [1:0] TRIG_LEVEL_C  = rx_regs_pkg::TRIG_LEVEL;

  // code from upper and lower mode bits picks the event type per source
  for (genvar i = 0; i < N; i++) begin : g_src
    logic [1:0] code;
    logic       fire;
    assign code = {mode_high[i], mode_low[i]};
    always_comb begin
      unique case (code)
        TRIG_ARRIVE_C: fire = mask[i] & src[i] & ~src_prev_q[i];
        TRIG_DEPART_C: fire = mask[i] & ~src[i] & src_prev_q[i];
        TRIG_LEVEL_C:  fire = mask[i] & src[i];
        default:       fire = 1'b0;  // reserved code never fires
      endcase
    end
    assign hit[i]  = fire;
    assign keep[i] = (code == TRIG_LEVEL_C) & mask[i] & src[i];
  end

  // sticky status; a new hit wins over the read clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (ce) begin
      status_q <= (rd_clear ? keep : status_q) | hit;
    end
  end

endmodule : irq2_trigger_unit

`default_nettype wire

/* hw/rx_error_and_irq_mode_regs.sv */
// receiver error, channel-status summary and interrupt trigger-mode registers
//
// Notes on behaviour
// - mode registers at 0Dh/0Eh; bits 5..0 per source, bits 7..6 read zero.
// - trigger code is upper-register bit over matching lower-register bit.
// - code 00 arrival, 01 removal, 10 level; 11 reserved, never programmed.
// - both mode registers reset to zero, arrival-edge mode.
// - error register at 10h read-only, bit 7 zero, bits 6..0 error flags.
// - subcode CRC flag bit 6, refreshed only at subcode block ends.
// - channel-status CRC flag bit 5, refreshed only at channel-status block ends.
// - channel-status CRC evaluated only in professional format.
// - biphase flag bit 1, refreshed on each sub-frame boundary.
// - reading second-bank status clears it, except live level-mode sources.
// - an error sets its flag only when its mask bit is one.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rx_error_and_irq_mode_regs (
  // clocking
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // receiver conditions, same clock
  input  wire rx_regs_pkg::rx_err_s       err_cond,
  input  wire logic                       subcode_blk_end,
  input  wire logic                       cs_blk_end,
  input  wire logic                       subframe_end,
  input  wire rx_regs_pkg::cs_summary_s   cs_in,
  // second-bank interrupt sources, bit 5 down to 0
  input  wire logic [5:0]                 irq2_src,
  // interrupt and error summary pins
  output logic                            irq_active,
  output logic                            receiver_error_summary
);

  // ==========================================================================
  // register state
  logic [5:0]                 mode_high_q;
  logic [5:0]                 mode_low_q;
  logic [5:0]                 irq2_mask_q;
  logic [6:0]                 err_mask_q;
  rx_regs_pkg::rx_err_s       err_q;
  rx_regs_pkg::cs_summary_s   cs_sum_q;
  logic [31:0]                prdata_q;
  logic                       pready_q;
  logic                       pslverr_q;
  logic                       irq_q;
  logic                       rx_sum_q;

  // ==========================================================================
  // address decode
  function automatic logic hit_idx(input logic [7:0] a, input logic [5:0] idx);
    hit_idx = (a[1:0] == 2'h0) && (a[7:2] == idx);
  endfunction : hit_idx

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit_idx(a, rx_regs_pkg::IDX_IRQ2_STATUS)
           | hit_idx(a, rx_regs_pkg::IDX_IRQ2_MASK)
           | hit_idx(a, rx_regs_pkg::IDX_TRIG_MODE_HIGH)
           | hit_idx(a, rx_regs_pkg::IDX_TRIG_MODE_LOW)
           | hit_idx(a, rx_regs_pkg::IDX_CS_SUMMARY)
           | hit_idx(a, rx_regs_pkg::IDX_RX_ERROR)
           | hit_idx(a, rx_regs_pkg::IDX_RX_ERROR_MASK);
  endfunction : mapped

  logic setup;
  logic done;
  logic wr;
  logic rd_err;
  logic rd_st;

  // transfer completes on the access edge where pready is already high
  assign setup  = psel & ~penable;
  assign done   = psel & penable & pready_q;
  assign wr     = done & pwrite & ~pslverr_q;
  assign rd_err = done & ~pwrite & hit_idx(paddr, rx_regs_pkg::IDX_RX_ERROR);
  assign rd_st  = done & ~pwrite & hit_idx(paddr, rx_regs_pkg::IDX_IRQ2_STATUS);

  // ==========================================================================
  // second-bank trigger unit
  logic [5:0] irq2_hit;
  logic [5:0] irq2_keep;
  logic [5:0] irq2_status;

  irq2_trigger_unit #(
    .N          (rx_regs_pkg::IRQ2_SRC_W)
  ) u_trig (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .mode_high  (mode_high_q),
    .mode_low   (mode_low_q),
    .mask       (irq2_mask_q),
    .src        (irq2_src),
    .rd_clear   (rd_st),
    .hit        (irq2_hit),
    .keep       (irq2_keep),
    .status_q   (irq2_status)
  );

  // ==========================================================================
  // writable configuration; reserved upper bits are not stored
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_high_q <= rx_regs_pkg::MODE_RESET[5:0];
      mode_low_q  <= rx_regs_pkg::MODE_RESET[5:0];
      irq2_mask_q <= rx_regs_pkg::MASK_RESET[5:0];
      err_mask_q  <= rx_regs_pkg::MASK_RESET[6:0];
    end else if (ce && wr) begin
      if (hit_idx(paddr, rx_regs_pkg::IDX_TRIG_MODE_HIGH)) begin
        mode_high_q <= pwdata[5:0];
      end
      if (hit_idx(paddr, rx_regs_pkg::IDX_TRIG_MODE_LOW)) begin
        mode_low_q <= pwdata[5:0];
      end
      if (hit_idx(paddr, rx_regs_pkg::IDX_IRQ2_MASK)) begin
        irq2_mask_q <= pwdata[5:0];
      end
      if (hit_idx(paddr, rx_regs_pkg::IDX_RX_ERROR_MASK)) begin
        err_mask_q <= pwdata[6:0];
      end
    end
  end

  // ==========================================================================
  // receiver error flags
  logic [6:0] err_bnd;
  logic [6:0] err_live;
  logic [6:0] err_set;
  logic [6:0] err_keep;

  // each flag refreshes only at its own boundary
  assign err_bnd = {subcode_blk_end,
                    cs_blk_end,
                    cs_blk_end,
                    subframe_end,
                    subframe_end,
                    subframe_end,
                    subframe_end};

  // crc of channel status means nothing in consumer streams
  always_comb begin
    err_live = err_cond & err_mask_q;
    err_live[rx_regs_pkg::ERR_BIT_CHANSTAT] =
      err_cond.chanstat_crc_error & err_mask_q[rx_regs_pkg::ERR_BIT_CHANSTAT]
      & cs_in.professional_format;
  end

  assign err_set  = err_live & err_bnd;
  // a read only keeps flags already set; it must never raise a new one
  assign err_keep = err_q & err_live;

  // sticky until read; an error landing on the read edge still sets
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      err_q <= '0;
    end else if (ce) begin
      err_q <= (rd_err ? err_keep : err_q) | err_set;
    end
  end

  // ==========================================================================
  // channel-status summary, caught at each block end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cs_sum_q <= rx_regs_pkg::CS_SUMMARY_RESET;
    end else if (ce && cs_blk_end) begin
      cs_sum_q         <= cs_in;
      if (cs_in.aux_len > rx_regs_pkg::AUX_LEN_MAX) begin
        cs_sum_q.aux_len <= rx_regs_pkg::AUX_LEN_MAX;  // clamp undefined lengths
      end
    end
  end

  // ==========================================================================
  // read mux, evaluated in the setup cycle so prdata comes from a flop
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_idx(paddr, rx_regs_pkg::IDX_TRIG_MODE_HIGH)) begin
      rd_mux[5:0] = mode_high_q;
    end
    if (hit_idx(paddr, rx_regs_pkg::IDX_TRIG_MODE_LOW)) begin
      rd_mux[5:0] = mode_low_q;
    end
    if (hit_idx(paddr, rx_regs_pkg::IDX_IRQ2_MASK)) begin
      rd_mux[5:0] = irq2_mask_q;
    end
    if (hit_idx(paddr, rx_regs_pkg::IDX_IRQ2_STATUS)) begin
      rd_mux[5:0] = irq2_status;
    end
    if (hit_idx(paddr, rx_regs_pkg::IDX_RX_ERROR)) begin
      rd_mux[6:0] = err_q;
    end
    if (hit_idx(paddr, rx_regs_pkg::IDX_RX_ERROR_MASK)) begin
      rd_mux[6:0] = err_mask_q;
    end
    if (hit_idx(paddr, rx_regs_pkg::IDX_CS_SUMMARY)) begin
      rd_mux[7:0] = cs_sum_q;
    end
  end

  // one wait-free access phase: answer raised in setup, dropped after done
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
        pready_q  <= 1'b1;
        // the error register refuses writes, like unmapped space
        pslverr_q <= ~mapped(paddr)
                   | (pwrite & hit_idx(paddr, rx_regs_pkg::IDX_RX_ERROR))
                   | (pwrite & hit_idx(paddr, rx_regs_pkg::IDX_CS_SUMMARY))
                   | (pwrite & hit_idx(paddr, rx_regs_pkg::IDX_IRQ2_STATUS));
      end else if (done) begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // registered pin outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_q    <= 1'b0;
      rx_sum_q <= 1'b0;
    end else if (ce) begin
      irq_q    <= |irq2_status;
      rx_sum_q <= |err_q;
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign irq_active             = irq_q;
  assign receiver_error_summary = rx_sum_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_mode_upper_zero: assert property (
    setup && !pwrite && (hit_idx(paddr, rx_regs_pkg::IDX_TRIG_MODE_HIGH)
      || hit_idx(paddr, rx_regs_pkg::IDX_TRIG_MODE_LOW)) && ce
    |=> prdata_q[31:6] == 26'h0)
    else $error("mode register upper bits not zero");

  chk_mode_reset_zero: assert property (
    $rose(rst_n) |-> (mode_high_q == 6'h00) && (mode_low_q == 6'h00))
    else $error("mode registers not zero after reset");

  chk_err_read_only: assert property (
    setup && pwrite && ce && hit_idx(paddr, rx_regs_pkg::IDX_RX_ERROR)
    |=> pslverr_q && !prdata_q[7])
    else $error("write to error register not refused");

  chk_subcode_boundary: assert property (
    $rose(err_q.subcode_crc_error) |-> $past(subcode_blk_end))
    else $error("subcode flag set off its block end");

  chk_chanstat_pro: assert property (
    $rose(err_q.chanstat_crc_error)
    |-> $past(cs_blk_end) && $past(cs_in.professional_format))
    else $error("chanstat flag set off block end or in consumer mode");

  chk_biphase_frame: assert property (
    $rose(err_q.biphase_error) |-> $past(subframe_end))
    else $error("biphase flag set off sub-frame boundary");

  chk_err_mask_gate: assert property (
    ((err_q & ~$past(err_q) & ~$past(err_mask_q)) == 7'h00))
    else $error("masked error set its flag");

  chk_err_read_clear: assert property (
    ce && rd_err |=> err_q == $past(err_keep | err_set))
    else $error("error read clear wrong");

  chk_irq2_read_clear: assert property (
    ce && rd_st |=> irq2_status == $past(irq2_keep | irq2_hit))
    else $error("irq status read clear wrong");

  chk_arrive_edge: assert property (
    ce && $past(ce) && irq2_mask_q[0] && !mode_high_q[0] && !mode_low_q[0]
      && irq2_src[0] && !$past(irq2_src[0])
    |=> irq2_status[0] ##1 irq_q)
    else $error("arrival edge did not raise status and pin");

  // ==========================================================================
  // checks on stored modes, removal edges, level hold and flag refresh
  chk_mode_high_stored: assert property (
    ce && wr && hit_idx(paddr, rx_regs_pkg::IDX_TRIG_MODE_HIGH)
    |=> mode_high_q == $past(pwdata[5:0]))
    else $error("upper mode register write lost");

  chk_mode_low_stored: assert property (
    ce && wr && hit_idx(paddr, rx_regs_pkg::IDX_TRIG_MODE_LOW)
    |=> mode_low_q == $past(pwdata[5:0]))
    else $error("lower mode register write lost");

  chk_depart_edge: assert property (
    ce && $past(ce) && irq2_mask_q[0] && !mode_high_q[0] && mode_low_q[0]
      && !irq2_src[0] && $past(irq2_src[0])
    |=> irq2_status[0])
    else $error("removal edge did not raise status");

  chk_level_hold: assert property (
    ce && rd_st && irq2_mask_q[0] && mode_high_q[0] && !mode_low_q[0]
      && irq2_src[0]
    |=> irq2_status[0])
    else $error("live level source cleared by read");

  chk_err_bit7_zero: assert property (
    setup && !pwrite && ce && hit_idx(paddr, rx_regs_pkg::IDX_RX_ERROR)
    |=> prdata_q[31:7] == 25'h0)
    else $error("error register upper bits not zero");

  chk_subcode_hold: assert property (
    ce && !subcode_blk_end && !rd_err
    |=> $stable(err_q.subcode_crc_error))
    else $error("subcode flag moved between block ends");

  chk_aux_len_range: assert property (
    cs_sum_q.aux_len <= rx_regs_pkg::AUX_LEN_MAX)
    else $error("aux length above eight");

  cov_read_error:  cover property (rd_err && (err_q != 7'h00));
  cov_level_keep:  cover property (rd_st && (irq2_keep != 6'h00));
  cov_depart_hit:  cover property (ce && mode_low_q[0] && !mode_high_q[0] && irq2_hit[0]);
  cov_unmapped:    cover property (done && pslverr_q);
  cov_aux_clamp:   cover property (ce && cs_blk_end && (cs_in.aux_len > rx_regs_pkg::AUX_LEN_MAX));

endmodule : rx_error_and_irq_mode_regs

`default_nettype wire

/* hw/rx_regs_pkg.sv */
// shared constants and carrier types for the receiver status register bank
package rx_regs_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_IRQ2_STATUS     = 6'h07;
  localparam logic [5:0] IDX_IRQ2_MASK       = 6'h0c;
  localparam logic [5:0] IDX_TRIG_MODE_HIGH  = 6'h0d;
  localparam logic [5:0] IDX_TRIG_MODE_LOW   = 6'h0e;
  localparam logic [5:0] IDX_CS_SUMMARY      = 6'h0f;
  localparam logic [5:0] IDX_RX_ERROR        = 6'h10;
  localparam logic [5:0] IDX_RX_ERROR_MASK   = 6'h11;

  // ==========================================================================
  // field layout
  localparam int          IRQ2_SRC_W         = 6;
  localparam int          RX_ERR_W           = 7;
  localparam int          ERR_BIT_SUBCODE    = 6;
  localparam int          ERR_BIT_CHANSTAT   = 5;
  localparam int          ERR_BIT_BIPHASE    = 1;
  localparam logic [3:0]  AUX_LEN_MAX        = 4'h8;

  // ==========================================================================
  // trigger codes, upper mode bit first
  localparam logic [1:0]  TRIG_ARRIVE        = 2'h0;
  localparam logic [1:0]  TRIG_DEPART        = 2'h1;
  localparam logic [1:0]  TRIG_LEVEL         = 2'h2;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  MODE_RESET         = 8'h00;
  localparam logic [7:0]  MASK_RESET         = 8'h00;
  localparam logic [7:0]  CS_SUMMARY_RESET   = 8'h00;

  // receiver error conditions, bit 6 down to bit 0
  typedef struct packed {
    logic subcode_crc_error;
    logic chanstat_crc_error;
    logic pll_unlock;
    logic validity;
    logic confidence;
    logic biphase_error;
    logic parity_error;
  } rx_err_s;

  // channel-status summary fields, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] aux_len;
    logic       professional_format;
    logic       non_audio;
    logic       copyright_free;
    logic       generation_indicator;
  } cs_summary_s;

endpackage : rx_regs_pkg

/* verification/apb_host_model.sv */
// apb host model that runs single register transfers for the bench
`timescale 1ns/1ps
`default_nettype none

module apb_host_model (
  // clock
  input  wire logic        core_clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ==========================================================================
  // idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // ==========================================================================
  // request held until pready is seen high at a rising edge, or given up as hung after 16 more edges; no fixed latency
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output logic hung);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge core_clk);
    end
    hung    = (pready !== 1'b1);
    rdata   = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_host_model
`default_nettype wire

/* verification/rx_error_and_irq_mode_regs_bench.sv */
// self-checking bench for the receiver status and trigger-mode register bank
`timescale 1ns/1ps
`default_nettype none

module rx_error_and_irq_mode_regs_bench;
  logic                     core_clk;
  logic                     rst_n;
  logic                     ce;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [7:0]               paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  rx_regs_pkg::rx_err_s     err_cond;
  logic                     subcode_blk_end;
  logic                     cs_blk_end;
  logic                     subframe_end;
  rx_regs_pkg::cs_summary_s cs_in;
  logic [5:0]               irq2_src;
  logic                     irq_active;
  logic                     receiver_error_summary;
  int                       num_errors;
  int                       num_checks;
  int                       i;
  int                       c;
  logic [15:0]              rnd;
  logic [7:0]               h;
  logic [7:0]               l;
  logic [7:0]               v;
  logic [5:0]               p;
  logic [5:0]               e;
  logic [31:0]              d;

  rx_error_and_irq_mode_regs rx_error_and_irq_mode_regs_i (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .err_cond(err_cond), .subcode_blk_end(subcode_blk_end),
    .cs_blk_end(cs_blk_end), .subframe_end(subframe_end), .cs_in(cs_in),
    .irq2_src(irq2_src), .irq_active(irq_active),
    .receiver_error_summary(receiver_error_summary));

  apb_host_model apb_host_model_i (
    .core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==========================================================================
  // helpers
  always #5 core_clk = ~core_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // long aux lengths saturate at eight
  function automatic logic [7:0] cs_exp(input logic [7:0] x);
    cs_exp = {(x[7:4] > 4'h8) ? 4'h8 : x[7:4], x[3:0]};
  endfunction : cs_exp

  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                     input logic experr, output logic [31:0] rd_q);
    logic err;
    logic hung;
    apb_host_model_i.xfer(wr, {idx, 2'b00}, wd, rd_q, err, hung);
    if (hung) begin
      num_errors++;
      stop_test();
    end else begin
      check("pslverr", {31'h0, err}, {31'h0, experr});
    end
  endtask : bus

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input string name);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, 1'b0, q);
    check(name, q, exp);
  endtask : rd

  // strobes order: subcode block, cs block, sub-frame
  task automatic strobe(input logic [2:0] w);
    {subcode_blk_end, cs_blk_end, subframe_end} <= w;
    @(posedge core_clk);
    {subcode_blk_end, cs_blk_end, subframe_end} <= 3'b000;
    @(posedge core_clk);
  endtask : strobe

  // watchdog well beyond the expected run of a few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    stop_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    core_clk = 1'b0; rst_n = 1'b0; ce = 1'b1; err_cond = '0; cs_in = '0; irq2_src = 6'h00;
    {subcode_blk_end, cs_blk_end, subframe_end} = 3'b000;
    num_errors = 0; num_checks = 0; rnd = 16'h8d35;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(rx_regs_pkg::IDX_TRIG_MODE_HIGH, 32'h0, "mode_high reset");
    rd(rx_regs_pkg::IDX_TRIG_MODE_LOW, 32'h0, "mode_low reset");
    rd(rx_regs_pkg::IDX_RX_ERROR, 32'h0, "rx_error reset");
    // random modes, lower bit cleared where upper is set so code 11 never goes out
    for (i = 0; i < 5; i++) begin
      rnd = lfsr(rnd); h = rnd[7:0];
      rnd = lfsr(rnd); l = rnd[7:0] & ~h;
      if (i == 0) begin h = 8'hff; l = 8'h00; end
      bus(1'b1, rx_regs_pkg::IDX_TRIG_MODE_LOW, 32'h0, 1'b0, d);
      bus(1'b1, rx_regs_pkg::IDX_TRIG_MODE_HIGH, {24'h0, h}, 1'b0, d);
      bus(1'b1, rx_regs_pkg::IDX_TRIG_MODE_LOW, {24'h0, l}, 1'b0, d);
      rd(rx_regs_pkg::IDX_TRIG_MODE_HIGH, {26'h0, h[5:0]}, "mode_high");
      rd(rx_regs_pkg::IDX_TRIG_MODE_LOW, {26'h0, l[5:0]}, "mode_low");
    end
    bus(1'b1, rx_regs_pkg::IDX_RX_ERROR, 32'hff, 1'b1, d);
    bus(1'b0, 6'h20, 32'h0, 1'b1, d);
    check("unmapped read", d, 32'h0);
    rd(rx_regs_pkg::IDX_RX_ERROR, 32'h0, "rx_error after write");
    // error flags: masked, then boundaries one at a time
    err_cond <= '1;
    strobe(3'b111);
    rd(rx_regs_pkg::IDX_RX_ERROR, 32'h0, "rx_error masked");
    bus(1'b1, rx_regs_pkg::IDX_RX_ERROR_MASK, 32'h7f, 1'b0, d);
    repeat (4) @(posedge core_clk);
    rd(rx_regs_pkg::IDX_RX_ERROR, 32'h0, "rx_error no boundary");
    strobe(3'b001);
    rd(rx_regs_pkg::IDX_RX_ERROR, 32'h0f, "rx_error subframe");
    strobe(3'b100);
    rd(rx_regs_pkg::IDX_RX_ERROR, 32'h4f, "rx_error subcode");
    strobe(3'b010);
    rd(rx_regs_pkg::IDX_RX_ERROR, 32'h5f, "rx_error consumer");
    cs_in <= 8'h08;
    strobe(3'b010);
    strobe(3'b010);
    rd(rx_regs_pkg::IDX_RX_ERROR, 32'h7f, "rx_error pro");
    check("error pin", {31'h0, receiver_error_summary}, 32'h1);
    err_cond <= '0;
    repeat (2) @(posedge core_clk);
    rd(rx_regs_pkg::IDX_RX_ERROR, 32'h7f, "rx_error sticky");
    rd(rx_regs_pkg::IDX_RX_ERROR, 32'h0, "rx_error cleared");
    repeat (2) @(posedge core_clk);
    check("error pin", {31'h0, receiver_error_summary}, 32'h0);
    // channel-status summary, aux length saturating corner first
    bus(1'b1, rx_regs_pkg::IDX_CS_SUMMARY, 32'h5a, 1'b1, d);
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd); v = (i == 0) ? 8'hf5 : rnd[7:0];
      cs_in <= v;
      strobe(3'b010);
      rd(rx_regs_pkg::IDX_CS_SUMMARY, {24'h0, cs_exp(v)}, "cs_summary");
    end
    // second-bank trigger codes 00, 01, 10 on a random source pattern
    bus(1'b1, rx_regs_pkg::IDX_IRQ2_MASK, 32'h3f, 1'b0, d);
    for (c = 0; c < 3; c++) begin
      rnd = lfsr(rnd); p = rnd[5:0] | 6'h01;
      bus(1'b1, rx_regs_pkg::IDX_TRIG_MODE_LOW, c[0] ? 32'h3f : 32'h0, 1'b0, d);
      bus(1'b1, rx_regs_pkg::IDX_TRIG_MODE_HIGH, c[1] ? 32'h3f : 32'h0, 1'b0, d);
      rd(rx_regs_pkg::IDX_IRQ2_STATUS, 32'h0, "irq2 idle");
      irq2_src <= p;
      repeat (3) @(posedge core_clk);
      e = (c != 1) ? p : 6'h00;
      check("irq pin", {31'h0, irq_active}, {31'h0, e != 6'h00});
      rd(rx_regs_pkg::IDX_IRQ2_STATUS, {26'h0, e}, "irq2 arrive");
      rd(rx_regs_pkg::IDX_IRQ2_STATUS, (c == 2) ? {26'h0, p} : 32'h0, "irq2 reread");
      irq2_src <= 6'h00;
      repeat (3) @(posedge core_clk);
      rd(rx_regs_pkg::IDX_IRQ2_STATUS, (c != 0) ? {26'h0, p} : 32'h0, "irq2 depart");
      rd(rx_regs_pkg::IDX_IRQ2_STATUS, 32'h0, "irq2 cleared");
    end
    // mixed codes per bit: upper three level, lower three removal
    bus(1'b1, rx_regs_pkg::IDX_TRIG_MODE_HIGH, 32'h38, 1'b0, d);
    bus(1'b1, rx_regs_pkg::IDX_TRIG_MODE_LOW, 32'h07, 1'b0, d);
    irq2_src <= 6'h3f;
    repeat (3) @(posedge core_clk);
    rd(rx_regs_pkg::IDX_IRQ2_STATUS, 32'h38, "irq2 mixed on");
    irq2_src <= 6'h00;
    repeat (3) @(posedge core_clk);
    rd(rx_regs_pkg::IDX_IRQ2_STATUS, 32'h3f, "irq2 mixed off");
    rd(rx_regs_pkg::IDX_IRQ2_STATUS, 32'h0, "irq2 mixed clear");
    stop_test();
  end
endmodule : rx_error_and_irq_mode_regs_bench
`default_nettype wire
